// *** rtl/osdpc_top.v ***
// osd pixel compositor: colour resolve, blink, spacing, stretch, lut, blend
// Functional notes
// RQ1: background-window mode supports four windows with colour and column/row bounds.
// RQ2: overlapping windows resolve by fixed priority.
// RQ3: window colour 00 gives transparent background.
// RQ4: windows off, 1bpp: foreground and background colour come from attribute.
// RQ5: windows off, 2bpp: background pixels use foreground colour 2.
// RQ6: blink needs attribute bit 8 and global blink enable.
// RQ7: blink off phase shows foreground as background; period/duty in frames.
// RQ8: programmed spacing inserts background pixels around each cell; the code inserts gaps along each line only, none between rows.
// RQ9: spacing is inserted before stretching, so gaps stretch too.
// RQ10: bitmap data fetched from frame buffer, decoded at 8/4/2/1 bpp.
// RQ11: bitmaps up to 512 by 512 pixels.
// RQ12: pixels resolve to 8-bit index, mapped via 256x24 lut.
// RQ13: index 00 is transparent, video passes unchanged.
// RQ14: host loads the lut through registers before use.
// RQ15: at most two bitmaps and one character image at once.
// RQ16: independent horizontal and vertical stretch by 2, 3 or 4.
// RQ17: sixteen blend levels, one for index >=128, one for <=127.
// RQ18: index 0 stays transparent whatever the blend level.
// RQ19: code 1111 is 6.25% overlay rising to 100% at 0000.
// RQ20: merge before or after scaler, one location for all images.
// RQ21: 1bpp background bits 7:1 from attribute 15:9, bit 0 zero.
// RQ22: 2bpp codes 11/10/01 pick fg 3/2/1, 00 picks background.
// RQ23: lowest-index window wins among overlaps.
// RQ24: blink counter advances per frame, compared with period and duty.
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "osdpc_consts.vh"
module osdpc_top #(
   parameter NWIN = 4
) (
   // clock and reset
   input  wire        sys_clk_in,
   input  wire        rst_in,
   // avalon-mm slave
   input  wire [5:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   output reg  [31:0] avs_readdata_out,
   output reg         avs_waitrequest_out,
   // display timing
   input  wire        frame_start_in,
   input  wire        pix_valid_in,
   input  wire        line_start_in,
   // character source: attribute and font code per pixel
   input  wire [23:0] char_attr_in,
   input  wire [1:0]  char_code_in,
   input  wire [7:0]  char_col_in,
   input  wire [7:0]  char_row_in,
   // frame buffer bitmap words, one per image
   input  wire [7:0]  fb0_data_in,
   input  wire [7:0]  fb1_data_in,
   // frame buffer fetch request
   output reg         fb_fetch_out,
   output reg  [9:0]  fb_x_out,
   output reg  [9:0]  fb_y_out,
   // video before and after the scaler
   input  wire [23:0] pre_video_in,
   input  wire [23:0] post_video_in,
   output reg  [23:0] pre_video_out,
   output reg  [23:0] post_video_out
);
   // ====================================================================
   // registers
   // ====================================================================
   reg  [31:0] ctrl_q;
   reg  [7:0]  blend_q;
   reg  [15:0] blink_q;
   reg  [3:0]  space_q;
   reg  [7:0]  stretch_q;
   reg  [7:0]  lut_addr_q;
   reg  [31:0] win_q [0:NWIN*2-1];
   reg         ack_q;
   reg  [7:0]  blink_cnt_q;
   wire        req = (avs_read_in | avs_write_in) & ~ack_q;
   wire [3:0]  widx = avs_address_in[5:2];
   // writes land at the edge where waitrequest is low
   wire        wr   = avs_write_in & ack_q;
   wire        lut_we = wr & (widx == `OSDPC_REG_LUT_DATA);   // see RQ14
   integer     i;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         ctrl_q              <= `OSDPC_CTRL_RESET;
         blend_q             <= 8'h00;
         blink_q             <= `OSDPC_BLINK_RESET;
         space_q             <= 4'h0;
         stretch_q           <= 8'h00;
         lut_addr_q          <= 8'h00;
         ack_q               <= 1'b0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
         for (i = 0; i < NWIN*2; i = i + 1) begin
            win_q[i] <= 32'h0000_0000;
         end
      end else begin
         ack_q               <= req;
         avs_waitrequest_out <= ~req;
         if (wr) begin
            if (widx == `OSDPC_REG_CTRL) ctrl_q <= avs_writedata_in;
            if (widx == `OSDPC_REG_BLEND) blend_q <= avs_writedata_in[7:0];
            if (widx == `OSDPC_REG_BLINK) blink_q <= avs_writedata_in[15:0];
            if (widx == `OSDPC_REG_SPACE) space_q <= avs_writedata_in[3:0];
            if (widx == `OSDPC_REG_STRETCH) stretch_q <= avs_writedata_in[7:0];
            if (widx == `OSDPC_REG_LUT_ADDR) lut_addr_q <= avs_writedata_in[7:0];
            if (lut_we) lut_addr_q <= lut_addr_q + 8'h01;
            if (widx >= `OSDPC_REG_WIN_BASE) win_q[widx[2:0]] <= avs_writedata_in;
         end
         if (avs_read_in & ~ack_q) begin
            case (widx)
               `OSDPC_REG_CTRL:     avs_readdata_out <= ctrl_q;
               `OSDPC_REG_BLEND:    avs_readdata_out <= {24'h00_0000, blend_q};
               `OSDPC_REG_BLINK:    avs_readdata_out <= {16'h0000, blink_q};
               `OSDPC_REG_SPACE:    avs_readdata_out <= {28'h000_0000, space_q};
               `OSDPC_REG_STRETCH:  avs_readdata_out <= {24'h00_0000, stretch_q};
               `OSDPC_REG_LUT_ADDR: avs_readdata_out <= {24'h00_0000, lut_addr_q};
               `OSDPC_REG_STATUS:   avs_readdata_out <= {14'h0000, fb_y_out, blink_cnt_q};
               `OSDPC_REG_LUT_DATA: avs_readdata_out <= 32'h0000_0000;
               default:             avs_readdata_out <= win_q[widx[2:0]];
            endcase
         end
      end
   end

   // ====================================================================
   // blink timing
   // ====================================================================
   wire [7:0] blink_period = blink_q[15:8];
   wire [7:0] blink_duty   = blink_q[7:0];
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         blink_cnt_q <= 8'h00;
      end else if (frame_start_in) begin
         if (blink_cnt_q + 8'h01 >= blink_period) blink_cnt_q <= 8'h00;   // see RQ24
         else blink_cnt_q <= blink_cnt_q + 8'h01;
      end
   end
   wire blink_off = blink_cnt_q >= blink_duty;   // see RQ7 RQ24

   // ====================================================================
   // stretch and spacing counters
   // ====================================================================
   function [1:0] osdpc_factor;
      input [1:0] code;
      begin
         osdpc_factor = code;   // 0 = x1, 1 = x2, 2 = x3, 3 = x4
      end
   endfunction
   wire [1:0] hfac = osdpc_factor(stretch_q[1:0]);   // see RQ16
   wire [1:0] vfac = osdpc_factor(stretch_q[3:2]);   // see RQ16
   reg  [1:0] hrep_q;
   reg  [1:0] vrep_q;
   reg  [9:0] bx_q;
   reg  [9:0] by_q;
   reg  [3:0] gap_q;
   wire       h_adv = pix_valid_in & (hrep_q == hfac);
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         hrep_q <= 2'b00;
         vrep_q <= 2'b00;
         bx_q   <= 10'h000;
         by_q   <= 10'h000;
         gap_q  <= 4'h0;
      end else begin
         if (frame_start_in) begin
            vrep_q <= 2'b00;
            by_q   <= 10'h000;
         end else if (line_start_in) begin
            vrep_q <= (vrep_q == vfac) ? 2'b00 : vrep_q + 2'b01;   // see RQ16
            if (vrep_q == vfac && by_q < `OSDPC_BMP_MAX) by_q <= by_q + 10'h001;   // see RQ11
         end
         if (line_start_in) begin
            hrep_q <= 2'b00;
            bx_q   <= 10'h000;
            gap_q  <= 4'h0;
         end else if (pix_valid_in) begin
            hrep_q <= h_adv ? 2'b00 : hrep_q + 2'b01;
            if (h_adv && bx_q < `OSDPC_BMP_MAX) bx_q <= bx_q + 10'h001;   // see RQ11
            // spacing counted in unstretched pixels so gaps stretch too
            if (h_adv) gap_q <= (gap_q == space_q) ? 4'h0 : gap_q + 4'h1;   // see RQ9
         end
      end
   end
   wire in_gap = (space_q != 4'h0) & (gap_q != 4'h0);   // see RQ8

   // ====================================================================
   // character colour resolve
   // ====================================================================
   reg  [7:0] char_bg;
   reg  [7:0] char_fg;
   reg  [7:0] char_idx;
   integer    w;
   always @* begin
      char_bg = 8'h00;
      // lowest index wins: scan from highest down
      for (w = NWIN-1; w >= 0; w = w - 1) begin   // see RQ1 RQ2 RQ23
         if (char_col_in >= win_q[2*w][7:0] && char_col_in <= win_q[2*w][15:8] &&
             char_row_in >= win_q[2*w][23:16] && char_row_in <= win_q[2*w][31:24]) begin
            char_bg = win_q[2*w+1][7:0];   // see RQ3
         end
      end
      if (!ctrl_q[`OSDPC_CTRL_WINMODE]) begin
         if (ctrl_q[`OSDPC_CTRL_TWOBPP])
            char_bg = {char_attr_in[23:20], char_attr_in[15:12]};   // see RQ5
         else
            char_bg = {char_attr_in[15:9], 1'b0};   // see RQ4 RQ21
      end
      if (ctrl_q[`OSDPC_CTRL_TWOBPP]) begin
         case (char_code_in)   // see RQ22
            2'b11:   char_fg = {char_attr_in[23:20], char_attr_in[19:17], 1'b0};
            2'b10:   char_fg = {char_attr_in[23:20], char_attr_in[15:12]};
            2'b01:   char_fg = {char_attr_in[23:20], char_attr_in[11:9], 1'b0};
            default: char_fg = char_bg;
         endcase
      end else begin
         char_fg = char_code_in[0] ? char_attr_in[23:16] : char_bg;   // see RQ4
      end
      char_idx = char_fg;
      if (char_attr_in[`OSDPC_ATTR_BLINK] & ctrl_q[`OSDPC_CTRL_BLINKEN] & blink_off)
         char_idx = char_bg;   // see RQ6 RQ7
      if (in_gap)
         char_idx = char_bg;   // see RQ8
      if (!ctrl_q[`OSDPC_CTRL_CHAREN])
         char_idx = 8'h00;
   end

   // ====================================================================
   // bitmap decode
   // ====================================================================
   function [7:0] osdpc_depth;
      input [7:0] word;
      input [1:0] depth;
      input [2:0] sub;
      begin
         case (depth)   // see RQ10
            2'b00:   osdpc_depth = word;
            2'b01:   osdpc_depth = sub[0] ? {4'h0, word[7:4]} : {4'h0, word[3:0]};
            2'b10:   osdpc_depth = {6'h00, word[2*sub[1:0] +: 2]};
            default: osdpc_depth = {7'h00, word[sub]};
         endcase
      end
   endfunction
   wire [1:0] depth  = ctrl_q[`OSDPC_CTRL_DEPTH_HI:`OSDPC_CTRL_DEPTH_LO];
   wire [7:0] b0_idx = ctrl_q[`OSDPC_CTRL_BMP0EN] ? osdpc_depth(fb0_data_in, depth, bx_q[2:0]) : 8'h00;
   wire [7:0] b1_idx = ctrl_q[`OSDPC_CTRL_BMP1EN] ? osdpc_depth(fb1_data_in, depth, bx_q[2:0]) : 8'h00;
   // character image on top, then bitmap 0, then bitmap 1; three planes only
   wire [7:0] pix_idx = (char_idx != 8'h00) ? char_idx :
                        (b0_idx != 8'h00) ? b0_idx : b1_idx;   // see RQ15

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         fb_fetch_out <= 1'b0;
         fb_x_out     <= 10'h000;
         fb_y_out     <= 10'h000;
      end else begin
         fb_fetch_out <= pix_valid_in & (ctrl_q[`OSDPC_CTRL_BMP0EN] | ctrl_q[`OSDPC_CTRL_BMP1EN]);   // see RQ10
         fb_x_out     <= bx_q;
         fb_y_out     <= by_q;
      end
   end

   // ====================================================================
   // lut, blend and merge
   // ====================================================================
   wire [23:0] lut_rgb;
   reg  [7:0]  idx_q;
   reg  [23:0] pre_q;
   reg  [23:0] post_q;
   osdpc_lut #(
      .DEPTH(256),
      .WIDTH(24)
   ) u_lut (
      .sys_clk_in  (sys_clk_in),
      .wr_en_in    (lut_we),
      .wr_addr_in  (lut_addr_q),
      .wr_data_in  (avs_writedata_in[23:0]),
      .rd_addr_in  (pix_idx),   // see RQ12
      .rd_data_out (lut_rgb)
   );
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         idx_q  <= 8'h00;
         pre_q  <= 24'h00_0000;
         post_q <= 24'h00_0000;
      end else begin
         idx_q  <= pix_idx;
         pre_q  <= pre_video_in;
         post_q <= post_video_in;
      end
   end
   wire [3:0]  level = (idx_q >= `OSDPC_BLEND_HALF) ? blend_q[7:4] : blend_q[3:0];   // see RQ17
   wire        merge_post = ctrl_q[`OSDPC_CTRL_MERGE];
   wire [23:0] under = merge_post ? post_q : pre_q;   // see RQ20
   wire [23:0] mixed;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ch
         osdpc_blend u_blend (
            .osd_in   (lut_rgb[8*g +: 8]),
            .video_in (under[8*g +: 8]),
            .level_in (level),   // see RQ19
            .mix_out  (mixed[8*g +: 8])
         );
      end
   endgenerate
   wire [23:0] result = (idx_q == 8'h00) ? under : mixed;   // see RQ13 RQ18

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pre_video_out  <= 24'h00_0000;
         post_video_out <= 24'h00_0000;
      end else begin
         pre_video_out  <= merge_post ? pre_q : result;    // see RQ20
         post_video_out <= merge_post ? result : post_q;   // see RQ20
      end
   end
endmodule
`default_nettype wire

// *** rtl/osdpc_consts.vh ***
// constants for the osd pixel compositor
`ifndef OSDPC_CONSTS_VH
`define OSDPC_CONSTS_VH
// register word offsets (byte address = 4 * index)
`define OSDPC_REG_CTRL      4'h0
`define OSDPC_REG_BLEND     4'h1
`define OSDPC_REG_BLINK     4'h2
`define OSDPC_REG_SPACE     4'h3
`define OSDPC_REG_STRETCH   4'h4
`define OSDPC_REG_LUT_ADDR  4'h5
`define OSDPC_REG_LUT_DATA  4'h6
`define OSDPC_REG_STATUS    4'h7
`define OSDPC_REG_WIN_BASE  4'h8
// control register bit positions
`define OSDPC_CTRL_WINMODE  0
`define OSDPC_CTRL_TWOBPP   1
`define OSDPC_CTRL_BLINKEN  2
`define OSDPC_CTRL_MERGE    3
`define OSDPC_CTRL_CHAREN   4
`define OSDPC_CTRL_BMP0EN   5
`define OSDPC_CTRL_BMP1EN   6
`define OSDPC_CTRL_DEPTH_LO 8
`define OSDPC_CTRL_DEPTH_HI 9
// attribute word fields
`define OSDPC_ATTR_BLINK    8
// reset values
`define OSDPC_CTRL_RESET    32'h0000_0000
`define OSDPC_BLINK_RESET   16'h1020
// blend and size constants
`define OSDPC_BLEND_HALF    8'h80
`define OSDPC_BMP_MAX       10'h200
`endif

// *** rtl/osdpc_lut.v ***
// 256 x 24-bit colour lookup table
`timescale 1ns/1ps
`default_nettype none
module osdpc_lut #(
   parameter DEPTH = 256,
   parameter WIDTH = 24
) (
   // clock
   input  wire             sys_clk_in,
   // host write port
   input  wire             wr_en_in,
   input  wire [7:0]       wr_addr_in,
   input  wire [WIDTH-1:0] wr_data_in,
   // pixel read port
   input  wire [7:0]       rd_addr_in,
   output reg  [WIDTH-1:0] rd_data_out
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   always @(posedge sys_clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_q[rd_addr_in];
   end
endmodule
`default_nettype wire

// *** rtl/osdpc_blend.v ***
// one-channel blender, 16 levels
`timescale 1ns/1ps
`default_nettype none
module osdpc_blend (
   // operands
   input  wire [7:0] osd_in,
   input  wire [7:0] video_in,
   input  wire [3:0] level_in,
   // result
   output wire [7:0] mix_out
);
   // code 0000 is all overlay, 1111 one sixteenth overlay
   wire [4:0]  share;
   wire [4:0]  rest;
   wire [12:0] sum;
   assign share   = 5'h10 - {1'b0, level_in};
   assign rest    = 5'h10 - share;
   assign sum     = {5'h00, osd_in} * {8'h00, share} + {5'h00, video_in} * {8'h00, rest};
   assign mix_out = sum[11:4];
endmodule
`default_nettype wire

// *** testbench/osdpc_top_chk.sv ***
// port assertions for the osd compositor
`timescale 1ns/1ps
`default_nettype none
module osdpc_top_chk (
   // clock and reset
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   // register bus
   input wire logic [5:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic        avs_waitrequest_out,
   // pixel side
   input wire logic        pix_valid_in,
   input wire logic [23:0] char_attr_in,
   input wire logic [1:0]  char_code_in,
   input wire logic        fb_fetch_out,
   input wire logic [9:0]  fb_x_out,
   input wire logic [9:0]  fb_y_out,
   input wire logic [23:0] pre_video_in,
   input wire logic [23:0] post_video_in,
   input wire logic [23:0] pre_video_out,
   input wire logic [23:0] post_video_out
);
   logic [6:0] ctrl_q;
   logic [1:0] age_q;
   logic       bm_off;
   logic       mpost;
   logic       tz;
   assign bm_off = ctrl_q[6:5] == 2'h0;
   assign mpost = ctrl_q[3];
   // background index zero in 1bpp with windows off
   assign tz = !char_code_in[0] && char_attr_in[15:9] == 7'h00 && ctrl_q[1:0] == 2'h0 && bm_off && pix_valid_in;
   // shadow of the control word, taken at the accepting edge
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ctrl_q <= 7'h00;
         age_q <= 2'h0;
      end else begin
         if (age_q != 2'h3) age_q <= age_q + 2'h1;
         if (avs_write_in && !avs_waitrequest_out && avs_address_in[5:2] == 4'h0) ctrl_q <= avs_writedata_in[6:0];
      end
   end
   default clocking dc @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_ack;
      (avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out;
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not answered");
   property p_wlen;
      !avs_waitrequest_out |=> avs_waitrequest_out;
   endproperty
   a_wlen: assert property (p_wlen) else $error("waitrequest low too long");
   property p_range;
      fb_fetch_out |-> fb_x_out <= 10'h200 && fb_y_out <= 10'h200;
   endproperty
   a_range: assert property (p_range) else $error("bitmap coordinate too large");
   property p_nofetch;
      age_q == 2'h3 && $past(bm_off, 2) && bm_off |-> !fb_fetch_out;
   endproperty
   a_nofetch: assert property (p_nofetch) else $error("fetch with bitmaps off");
   property p_postpass;
      age_q == 2'h3 && !$past(mpost, 2) && !mpost |-> post_video_out == $past(post_video_in, 2);
   endproperty
   a_postpass: assert property (p_postpass) else $error("post video altered");
   property p_prepass;
      age_q == 2'h3 && $past(mpost, 2) && mpost |-> pre_video_out == $past(pre_video_in, 2);
   endproperty
   a_prepass: assert property (p_prepass) else $error("pre video altered");
   property p_tpost;
      age_q == 2'h3 && $past(tz, 2) && $past(mpost, 2) && mpost |-> post_video_out == $past(post_video_in, 2);
   endproperty
   a_tpost: assert property (p_tpost) else $error("index zero not transparent");
   property p_tpre;
      age_q == 2'h3 && $past(tz, 2) && !$past(mpost, 2) && !mpost |-> pre_video_out == $past(pre_video_in, 2);
   endproperty
   a_tpre: assert property (p_tpre) else $error("index zero blended");
endmodule
bind osdpc_top osdpc_top_chk u_osdpc_top_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
   .pix_valid_in(pix_valid_in), .char_attr_in(char_attr_in), .char_code_in(char_code_in),
   .fb_fetch_out(fb_fetch_out), .fb_x_out(fb_x_out), .fb_y_out(fb_y_out),
   .pre_video_in(pre_video_in), .post_video_in(post_video_in),
   .pre_video_out(pre_video_out), .post_video_out(post_video_out));
`default_nettype wire

// *** testbench/osdpc_far_model.sv ***
// frame buffer and scaler model at the compositor's far side
`timescale 1ns/1ps
`default_nettype none
module osdpc_far_model (
   // clock
   input wire logic        sys_clk_in,
   // fetch and video from the compositor
   input wire logic        fb_fetch_in,
   input wire logic [9:0]  fb_x_in,
   input wire logic [9:0]  fb_y_in,
   input wire logic [23:0] pre_video_in,
   // answers
   output logic [7:0]      fb0_data_out,
   output logic [7:0]      fb1_data_out,
   output logic [23:0]     post_video_out
);
   initial begin
      fb0_data_out = 8'h00;
      fb1_data_out = 8'h00;
      post_video_out = 24'h00_0000;
   end
   // scaler stage is one register; data lines toggle when not fetched
   always @(posedge sys_clk_in) begin
      post_video_out <= pre_video_in;
      if (fb_fetch_in) begin
         fb0_data_out <= fb_x_in[7:0] ^ fb_y_in[7:0];
         fb1_data_out <= ~fb_x_in[7:0];
      end else begin
         fb0_data_out <= ~fb0_data_out;
         fb1_data_out <= ~fb1_data_out;
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the osd compositor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [23:0] VID = 24'h13_579b;
   logic        sys_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [5:0]  avs_address_in = 6'h00;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000;
   logic [31:0] avs_readdata_out, rdq;
   logic        avs_waitrequest_out, fb_fetch_out;
   logic        frame_start_in = 1'b0;
   logic        line_start_in = 1'b0;
   logic        pix_valid_in = 1'b1;
   logic [23:0] char_attr_in = 24'h00_0000;
   logic [1:0]  char_code_in = 2'h0;
   logic [7:0]  char_col_in = 8'h00;
   logic [7:0]  char_row_in = 8'h00;
   logic [7:0]  fb0_data_in, fb1_data_in;
   logic [9:0]  fb_x_out, fb_y_out;
   logic [23:0] pre_video_in = 24'h00_0000;
   logic [23:0] post_video_in, pre_video_out, post_video_out;
   int          errors = 0;
   int          samples_checked = 0;
   int          on, off;
   logic [7:0]  cols [7] = '{8'h23, 8'h24, 8'h26, 8'h36, 8'h41, 8'h52, 8'h90};
   always #12.5 sys_clk_in = ~sys_clk_in;
   osdpc_top u_osdpc_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .frame_start_in(frame_start_in), .pix_valid_in(pix_valid_in), .line_start_in(line_start_in),
      .char_attr_in(char_attr_in), .char_code_in(char_code_in), .char_col_in(char_col_in),
      .char_row_in(char_row_in), .fb0_data_in(fb0_data_in), .fb1_data_in(fb1_data_in),
      .fb_fetch_out(fb_fetch_out), .fb_x_out(fb_x_out), .fb_y_out(fb_y_out),
      .pre_video_in(pre_video_in), .post_video_in(post_video_in),
      .pre_video_out(pre_video_out), .post_video_out(post_video_out));
   osdpc_far_model u_osdpc_far_model (.sys_clk_in(sys_clk_in), .fb_fetch_in(fb_fetch_out),
      .fb_x_in(fb_x_out), .fb_y_in(fb_y_out), .pre_video_in(pre_video_out),
      .fb0_data_out(fb0_data_in), .fb1_data_out(fb1_data_in), .post_video_out(post_video_in));
   // =====================================
   // helpers
   task automatic stop_test;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [31:0] cf(input logic [7:0] i);
      return {8'h00, i, i, i};
   endfunction
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
      int n;
      @(posedge sys_clk_in);
      avs_address_in <= {idx, 2'b00};
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      n = 0;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 100);
      rdq = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (n >= 100) begin
         errors++;
         stop_test();
      end
   endtask
   task automatic px(input logic [23:0] a, input logic [1:0] c, input logic [7:0] col, input logic [23:0] v);
      @(posedge sys_clk_in);
      char_attr_in <= a;
      char_code_in <= c;
      char_col_in <= col;
      char_row_in <= 8'h01;
      pre_video_in <= v;
      repeat (8) @(posedge sys_clk_in);
   endtask
   task automatic frames(input logic [31:0] ctrl, input logic [23:0] a);
      bus(1'b1, 4'h0, ctrl);
      px(a, 2'h1, 8'h02, VID);
      on = 0;
      off = 0;
      repeat (8) begin
         @(posedge sys_clk_in);
         frame_start_in <= 1'b1;
         @(posedge sys_clk_in);
         frame_start_in <= 1'b0;
         repeat (8) @(posedge sys_clk_in);
         if ({8'h00, post_video_out} === cf(8'h24)) on++;
         if ({8'h00, post_video_out} === cf(8'h36)) off++;
      end
   endtask
   // =====================================
   // scenarios
   task automatic t_regs;
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk("blink reg", 32'h0000_1020, rdq);
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk("ctrl reg", 32'h0000_0000, rdq);
      bus(1'b0, 4'h6, 32'h0000_0000);
      chk("lut data read", 32'h0000_0000, rdq);
   endtask
   task automatic t_char;
      bus(1'b1, 4'h0, 32'h0000_0018);
      bus(1'b1, 4'h1, 32'h0000_0000);
      px(24'h24_3600, 2'h1, 8'h02, VID);
      chk("fg 1bpp", cf(8'h24), {8'h00, post_video_out});
      px(24'h24_3600, 2'h0, 8'h02, VID);
      chk("bg 1bpp", cf(8'h36), {8'h00, post_video_out});
      px(24'h24_0000, 2'h0, 8'h02, VID);
      chk("index zero", {8'h00, VID}, {8'h00, post_video_out});
      bus(1'b1, 4'h0, 32'h0000_001a);
      px(24'h24_3600, 2'h2, 8'h02, VID);
      chk("fg2", cf(8'h23), {8'h00, post_video_out});
      px(24'h24_3600, 2'h0, 8'h02, VID);
      chk("bg 2bpp", cf(8'h23), {8'h00, post_video_out});
      px(24'h24_3600, 2'h1, 8'h02, VID);
      chk("fg1", cf(8'h26), {8'h00, post_video_out});
      bus(1'b1, 4'h0, 32'h0000_0010);
      px(24'h24_3600, 2'h1, 8'h02, VID);
      chk("pre merge", cf(8'h24), {8'h00, pre_video_out});
      px(24'h24_0000, 2'h0, 8'h02, VID);
      chk("pre index zero", {8'h00, VID}, {8'h00, pre_video_out});
   endtask
   task automatic t_win;
      bus(1'b1, 4'h8, 32'h0900_0300);
      bus(1'b1, 4'h9, 32'h0000_0041);
      bus(1'b1, 4'ha, 32'h0900_0700);
      bus(1'b1, 4'hb, 32'h0000_0052);
      bus(1'b1, 4'hc, 32'h0900_0c0a);
      bus(1'b1, 4'hd, 32'h0000_0000);
      bus(1'b1, 4'hf, 32'h0000_0000);
      bus(1'b1, 4'h0, 32'h0000_0019);
      px(24'h24_3600, 2'h0, 8'h02, VID);
      chk("overlap", cf(8'h41), {8'h00, post_video_out});
      px(24'h24_3600, 2'h0, 8'h05, VID);
      chk("window 1", cf(8'h52), {8'h00, post_video_out});
      px(24'h24_3600, 2'h0, 8'h0b, VID);
      chk("clear window", {8'h00, VID}, {8'h00, post_video_out});
      px(24'h24_3600, 2'h1, 8'h02, VID);
      chk("window fg", cf(8'h24), {8'h00, post_video_out});
   endtask
   task automatic t_blend;
      bus(1'b1, 4'h0, 32'h0000_0018);
      bus(1'b1, 4'h1, 32'h0000_0080);
      px(24'h90_3600, 2'h1, 8'h02, 24'h00_0000);
      chk("half blend", 32'h0048_4848, {8'h00, post_video_out});
      px(24'h24_3600, 2'h1, 8'h02, 24'h00_0000);
      chk("low level", cf(8'h24), {8'h00, post_video_out});
      bus(1'b1, 4'h1, 32'h0000_0000);
   endtask
   task automatic t_blink;
      bus(1'b1, 4'h2, 32'h0000_0402);
      frames(32'h0000_001c, 24'h24_3700);
      chk("blink mix", 32'h0000_0003, {30'h0000_0000, on != 0, off != 0});
      frames(32'h0000_0018, 24'h24_3700);
      chk("blink off", 32'h0000_0008, on);
      frames(32'h0000_001c, 24'h24_3600);
      chk("no attr blink", 32'h0000_0008, on);
   endtask
   task automatic t_fetch;
      int n;
      bus(1'b1, 4'h0, 32'h0000_0028);
      bus(1'b1, 4'h4, 32'h0000_0004);
      on = 0;
      for (n = 0; n < 400; n++) begin
         @(posedge sys_clk_in);
         line_start_in <= n % 40 == 0;
         frame_start_in <= n == 0;
         if (fb_fetch_out === 1'b1) on = 1;
      end
      chk("fetch", 32'h0000_0001, on);
      chk("line count", 32'h0000_0004, fb_y_out);
   endtask
   initial begin
      #2500000;
      errors++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_regs();
      foreach (cols[k]) begin
         bus(1'b1, 4'h5, {24'h00_0000, cols[k]});
         bus(1'b1, 4'h6, cf(cols[k]));
      end
      t_char();
      t_win();
      t_blend();
      t_blink();
      t_fetch();
      stop_test();
   end
endmodule
`default_nettype wire
